/* logic/ictl_pkg.sv */
/*
 * Package for the interrupt control and trap status block: register
 * offsets, field positions, reset values and the bus carrier structs.
 * Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
 */
package ictl_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;

    localparam logic [11:0] OFF_CTL_ONE   = 12'h000;
    localparam logic [11:0] OFF_CTL_TWO   = 12'h004;
    localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK  = 12'h00c;
    localparam logic [11:0] OFF_CPU_PRIO  = 12'h010;

    localparam int BIT_NEST_DIS  = 15;
    localparam int BIT_ARITH     = 4;
    localparam int BIT_ADDR      = 3;
    localparam int BIT_STACK     = 2;
    localparam int BIT_OSC       = 1;
    localparam int BIT_ALT_VEC   = 15;
    localparam int BIT_DISABLE_INSTR_ACTIVE      = 14;

    localparam logic [15:0] CTL_ONE_MASK  = 16'h801e;
    localparam logic [15:0] CTL_TWO_WMASK = 16'h8007;
    localparam logic [15:0] CTL_ONE_RST   = 16'h0000;
    localparam logic [15:0] CTL_TWO_RST   = 16'h0000;
    localparam logic [3:0]  PRIO_RST      = 4'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef struct packed {
        logic [3:0] osc_arith_addr_stack;
    } ictl_trap_s;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } ictl_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ictl_axi_rsp_s;

endpackage : ictl_pkg

/* logic/ictl_top.sv */
/*
 * Interrupt control and trap status registers with AXI4-Lite access,
 * external edge detection, priority level store and interrupt output.
 * Assumes trap pulses, pin levels and countdown status are synchronous.
 */
`timescale 1ns/1ps

module ictl_top (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire ictl_pkg::ictl_axi_req_s axi_req,
    output ictl_pkg::ictl_axi_rsp_s      axi_rsp,
    input  wire logic                   trap_arith,
    input  wire logic                   trap_addr,
    input  wire logic                   trap_stack,
    input  wire logic                   trap_osc,
    input  wire logic                   disable_instr_active_countdown,
    input  wire logic [2:0]             ext_irq_pin,
    output logic                        nesting_disable,
    output logic                        alt_vector_select,
    output logic [3:0]                  cpu_priority_level,
    output logic [2:0]                  ext_irq_req,
    output logic                        irq
);
    import ictl_pkg::*;

    typedef struct packed {
        ictl_axi_rsp_s rsp;
        logic          aw_held;
        logic [11:0]   aw_addr;
        logic          w_held;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic [15:0]   ctl_one;
        logic [15:0]   ctl_two;
        logic [3:0]    prio;
        logic [2:0]    pin_d;
        logic [2:0]    ext_req;
        logic [6:0]    stat;
        logic [6:0]    mask;
        logic          irq;
    } ictl_state_s;

    ictl_state_s st;
    ictl_state_s next_st;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = old_v;
        if (be[0]) merge16[7:0]  = wd[7:0];
        if (be[1]) merge16[15:8] = wd[15:8];
    endfunction : merge16

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a == OFF_CTL_ONE) || (a == OFF_CTL_TWO) || (a == OFF_IRQ_STAT)
                  || (a == OFF_IRQ_MASK) || (a == OFF_CPU_PRIO);
    endfunction : known_addr

    logic [3:0]  trap_vec;
    logic [2:0]  edge_hit;
    logic        do_write;
    logic [15:0] wv;
    logic [15:0] rd_val;

    assign trap_vec = {trap_arith, trap_addr, trap_stack, trap_osc};

    always_comb
    begin
        next_st  = st;
        edge_hit = 3'b000;
        wv       = 16'h0000;
        rd_val   = 16'h0000;
        do_write = 1'b0;

        // Hold address and data until both arrive
        if (axi_req.awvalid && st.rsp.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = {axi_req.awaddr[11:2], 2'b00};
        end
        if (axi_req.wvalid && st.rsp.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = axi_req.wdata;
            next_st.w_strb = axi_req.wstrb;
        end
        next_st.rsp.awready = !next_st.aw_held && !st.rsp.bvalid;
        next_st.rsp.wready  = !next_st.w_held && !st.rsp.bvalid;

        if (st.aw_held && st.w_held && !st.rsp.bvalid)
        begin
            do_write            = 1'b1;
            next_st.aw_held     = 1'b0;
            next_st.w_held      = 1'b0;
            next_st.rsp.bvalid  = 1'b1;
            next_st.rsp.bresp   = known_addr(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            next_st.rsp.awready = 1'b0;
            next_st.rsp.wready  = 1'b0;
        end
        if (st.rsp.bvalid && axi_req.bready)
        begin
            next_st.rsp.bvalid  = 1'b0;
            next_st.rsp.awready = 1'b1;
            next_st.rsp.wready  = 1'b1;
        end

        if (do_write)
        begin
            unique case (st.aw_addr)
                OFF_CTL_ONE:
                begin
                    wv = merge16(st.ctl_one, st.w_data, st.w_strb);
                    next_st.ctl_one = wv & CTL_ONE_MASK;
                end
                OFF_CTL_TWO:
                begin
                    wv = merge16(st.ctl_two, st.w_data, st.w_strb);
                    next_st.ctl_two = wv & CTL_TWO_WMASK;
                end
                OFF_IRQ_STAT:
                begin
                    if (st.w_strb[0])
                        next_st.stat = st.stat & ~st.w_data[6:0];
                end
                OFF_IRQ_MASK:
                begin
                    if (st.w_strb[0])
                        next_st.mask = st.w_data[6:0];
                end
                OFF_CPU_PRIO:
                begin
                    if (st.w_strb[0] && !st.ctl_one[BIT_NEST_DIS])
                        next_st.prio = st.w_data[3:0];
                end
                default:
                begin
                    wv = 16'h0000;
                end
            endcase
        end

        next_st.ctl_one[BIT_ARITH:BIT_OSC] = next_st.ctl_one[BIT_ARITH:BIT_OSC] | trap_vec;

        next_st.ctl_two[BIT_DISABLE_INSTR_ACTIVE] = disable_instr_active_countdown;

        for (int i = 0; i < 3; i++)
        begin
            edge_hit[i] = st.ctl_two[i] ? (st.pin_d[i] && !ext_irq_pin[i])
                                        : (!st.pin_d[i] && ext_irq_pin[i]);
        end
        next_st.pin_d   = ext_irq_pin;
        next_st.ext_req = edge_hit;

        // Events: traps low four, edges high three; set wins
        next_st.stat = next_st.stat | {edge_hit, trap_vec};
        next_st.irq  = |(next_st.stat & next_st.mask);

        // Read channel
        if (st.rsp.rvalid && axi_req.rready)
        begin
            next_st.rsp.rvalid  = 1'b0;
            next_st.rsp.arready = 1'b1;
        end
        if (axi_req.arvalid && st.rsp.arready)
        begin
            unique case ({axi_req.araddr[11:2], 2'b00})
                OFF_CTL_ONE:  rd_val = st.ctl_one;
                OFF_CTL_TWO:  rd_val = st.ctl_two;
                OFF_IRQ_STAT: rd_val = {9'h000, st.stat};
                OFF_IRQ_MASK: rd_val = {9'h000, st.mask};
                OFF_CPU_PRIO: rd_val = {12'h000, st.prio};
                default:      rd_val = 16'h0000;
            endcase
            next_st.rsp.rvalid  = 1'b1;
            next_st.rsp.arready = 1'b0;
            next_st.rsp.rdata   = {16'h0000, rd_val};
            next_st.rsp.rresp   = known_addr({axi_req.araddr[11:2], 2'b00})
                                  ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st             <= '0;
            st.rsp.awready <= 1'b1;
            st.rsp.wready  <= 1'b1;
            st.rsp.arready <= 1'b1;
            st.ctl_one     <= CTL_ONE_RST;
            st.ctl_two     <= CTL_TWO_RST;
            st.prio        <= PRIO_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign axi_rsp            = st.rsp;
    assign nesting_disable    = st.ctl_one[BIT_NEST_DIS];
    assign alt_vector_select  = st.ctl_two[BIT_ALT_VEC];
    assign cpu_priority_level = st.prio;
    assign ext_irq_req        = st.ext_req;
    assign irq                = st.irq;

    property p_arith_set;
        @(posedge clk) disable iff (rst) trap_arith |=> st.ctl_one[BIT_ARITH];
    endproperty
    a_arith_set: assert property (p_arith_set) else $error("arith flag not set");

    property p_addr_set;
        @(posedge clk) disable iff (rst) trap_addr |=> st.ctl_one[BIT_ADDR];
    endproperty
    a_addr_set: assert property (p_addr_set) else $error("addr flag not set");

    property p_stack_set;
        @(posedge clk) disable iff (rst) trap_stack |=> st.ctl_one[BIT_STACK];
    endproperty
    a_stack_set: assert property (p_stack_set) else $error("stack flag not set");

    property p_osc_set;
        @(posedge clk) disable iff (rst) trap_osc |=> st.ctl_one[BIT_OSC];
    endproperty
    a_osc_set: assert property (p_osc_set) else $error("osc flag not set");

    property p_unimpl_zero;
        @(posedge clk) disable iff (rst)
            ((st.ctl_one & ~CTL_ONE_MASK) == 16'h0000) && (st.ctl_two[13:3] == 11'h000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

    sequence s_fall(int i);
        st.ctl_two[i] && st.pin_d[i] && !ext_irq_pin[i];
    endsequence
    property p_fall_edge;
        @(posedge clk) disable iff (rst) s_fall(0) |=> ext_irq_req[0];
    endproperty
    a_fall_edge: assert property (p_fall_edge) else $error("falling edge missed");

    property p_rise_edge;
        @(posedge clk) disable iff (rst)
            (!st.ctl_two[1] && !st.pin_d[1] && ext_irq_pin[1]) |=> ext_irq_req[1];
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed");

    property p_prio_lock;
        @(posedge clk) disable iff (rst) nesting_disable |=> $stable(cpu_priority_level);
    endproperty
    a_prio_lock: assert property (p_prio_lock) else $error("level changed while locked");

    property p_disable_instr_active_track;
        @(posedge clk) disable iff (rst) disable_instr_active_countdown |=> st.ctl_two[BIT_DISABLE_INSTR_ACTIVE];
    endproperty
    a_disable_instr_active_track: assert property (p_disable_instr_active_track) else $error("countdown status wrong");

    property p_irq_level;
        @(posedge clk) disable iff (rst) (|(st.stat & st.mask)) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt output low");

    sequence s_rise(int i);
        !st.ctl_two[i] && !st.pin_d[i] && ext_irq_pin[i];
    endsequence
    property p_rise_edge0;
        @(posedge clk) disable iff (rst) s_rise(0) |=> ext_irq_req[0];
    endproperty
    a_rise_edge0: assert property (p_rise_edge0) else $error("rising edge 0 missed");

    property p_fall_edge2;
        @(posedge clk) disable iff (rst) s_fall(2) |=> ext_irq_req[2];
    endproperty
    a_fall_edge2: assert property (p_fall_edge2) else $error("falling edge 2 missed");

    property p_no_stray_edge;
        @(posedge clk) disable iff (rst)
            (ext_irq_pin == st.pin_d) |=> (ext_irq_req == 3'b000);
    endproperty
    a_no_stray_edge: assert property (p_no_stray_edge) else $error("pulse without edge");

    property p_bvalid_hold;
        @(posedge clk) disable iff (rst)
            (axi_rsp.bvalid && !axi_req.bready) |=> axi_rsp.bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

    property p_rvalid_hold;
        @(posedge clk) disable iff (rst)
            (axi_rsp.rvalid && !axi_req.rready) |=> (axi_rsp.rvalid && $stable(axi_rsp.rdata));
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");

endmodule : ictl_top

/* verification/ictl_core_model.sv */
/*
 * Core-side model: single-cycle trap events and a disable countdown.
 * Assumes the bench requests events with one-cycle pulses on fire/disable_instr_active_go.
 */
`timescale 1ns/1ps
module ictl_core_model #(
    parameter int DISABLE_INSTR_ACTIVE_CYC = 8
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] fire,
    input  wire logic       disable_instr_active_go,
    output logic [3:0]      trap,
    output logic            disable_instr_active_countdown
);
    logic [7:0] cnt;

    // Traps last one cycle; countdown holds a level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trap <= 4'h0;
            cnt  <= 8'h00;
        end
        else
        begin
            trap <= fire;
            if (disable_instr_active_go)
                cnt <= 8'(DISABLE_INSTR_ACTIVE_CYC);
            else if (cnt != 8'h00)
                cnt <= cnt - 8'h01;
        end
    end
    assign disable_instr_active_countdown = (cnt != 8'h00);
endmodule : ictl_core_model

/* verification/tb.sv */
/*
 * Bench for ictl_top: register, trap, edge and interrupt tests over AXI4-Lite.
 * Assumes the package and the core model are compiled first.
 */
`timescale 1ns/1ps
module tb;
    import ictl_pkg::*;
    logic          clk;
    logic          rst;
    ictl_axi_req_s req;
    ictl_axi_rsp_s rsp;
    logic [3:0]    fire;
    logic          disable_instr_active_go;
    logic [3:0]    trap;
    logic          disable_instr_active_cd;
    logic [2:0]    pins;
    logic          nest;
    logic          alt;
    logic [3:0]    prio;
    logic [2:0]    ereq;
    logic          irq;
    logic [31:0]   d;
    logic [1:0]    r;
    logic [7:0]    pcnt;
    logic [7:0]    base;
    int            sel;
    int            n_fail;
    int            compares;
    int            cyc;

    ictl_core_model u_ictl_core_model (.clk(clk), .rst(rst), .fire(fire), .disable_instr_active_go(disable_instr_active_go),
        .trap(trap), .disable_instr_active_countdown(disable_instr_active_cd));
    ictl_top u_ictl_top (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .trap_arith(trap[3]), .trap_addr(trap[2]), .trap_stack(trap[1]), .trap_osc(trap[0]),
        .disable_instr_active_countdown(disable_instr_active_cd), .ext_irq_pin(pins), .nesting_disable(nest),
        .alt_vector_select(alt), .cpu_priority_level(prio), .ext_irq_req(ereq), .irq(irq));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task tally_and_finish;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task axi_wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {16'h0000, v};
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : axi_wr

    task axi_rd(input logic [11:0] a);
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : axi_rd

    task pulse(input logic [3:0] f);
        @(posedge clk) fire <= f;
        @(posedge clk) fire <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : pulse

    // Edge pulses seen on the selected channel
    always @(posedge clk)
    begin
        cyc++;
        if (ereq[sel])
            pcnt <= pcnt + 8'h01;
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish;
        end
    end

    initial
    begin
        req = '0;
        rst = 1'b1;
        fire = 4'h0;
        disable_instr_active_go = 1'b0;
        pins = 3'h0;
        pcnt = 8'h00;
        sel = 0;
        n_fail = 0;
        compares = 0;
        cyc = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        axi_rd(OFF_CTL_ONE);
        chk("ctl_one reset", 32'h0, d);
        axi_rd(OFF_CTL_TWO);
        chk("ctl_two reset", 32'h0, d);
        axi_wr(OFF_CTL_ONE, 16'hffff);
        chk("mapped bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_rd(OFF_CTL_ONE);
        chk("mapped rresp", {30'h0, RESP_OKAY}, {30'h0, r});
        chk("ctl_one", 32'h801e, d);
        chk("nesting", 32'h1, {31'h0, nest});
        axi_wr(OFF_CPU_PRIO, 16'h0009);
        axi_rd(OFF_CPU_PRIO);
        chk("prio locked", 32'h0, d);
        axi_wr(OFF_CTL_ONE, 16'h0000);
        axi_wr(OFF_CPU_PRIO, 16'h0009);
        axi_rd(OFF_CPU_PRIO);
        chk("prio", 32'h9, d);
        chk("prio port", 32'h9, {28'h0, prio});
        axi_wr(OFF_CTL_TWO, 16'hffff);
        axi_rd(OFF_CTL_TWO);
        chk("ctl_two", 32'h8007, d);
        chk("alt vector", 32'h1, {31'h0, alt});
        axi_wr(OFF_CTL_TWO, 16'h0000);
        chk("alt vector off", 32'h0, {31'h0, alt});
        @(posedge clk) disable_instr_active_go <= 1'b1;
        @(posedge clk) disable_instr_active_go <= 1'b0;
        axi_rd(OFF_CTL_TWO);
        chk("disable_instr_active on", 32'h4000, d);
        repeat (12) @(posedge clk);
        axi_rd(OFF_CTL_TWO);
        chk("disable_instr_active off", 32'h0, d);
        axi_wr(OFF_IRQ_MASK, 16'h0000);
        pulse(4'h8);
        chk("irq masked", 32'h0, {31'h0, irq});
        axi_wr(OFF_IRQ_MASK, 16'h007f);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        axi_wr(OFF_IRQ_STAT, 16'h007f);
        axi_wr(OFF_CTL_ONE, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            pulse(4'h1 << i);
            axi_rd(OFF_CTL_ONE);
            chk("trap flag", 32'h1 << (i + 1), d);
            axi_rd(OFF_IRQ_STAT);
            chk("status", 32'h1 << i, d);
            chk("irq", 32'h1, {31'h0, irq});
            axi_wr(OFF_CTL_ONE, 16'h0000);
            axi_wr(OFF_IRQ_STAT, 16'h007f);
            axi_rd(OFF_CTL_ONE);
            chk("trap cleared", 32'h0, d);
            chk("irq cleared", 32'h0, {31'h0, irq});
            axi_rd(OFF_IRQ_STAT);
            chk("status cleared", 32'h0, d);
        end
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 3; c++)
            begin
                sel = c;
                axi_wr(OFF_CTL_TWO, (p != 0) ? 16'h0007 : 16'h0000);
                base = pcnt;
                @(posedge clk) pins <= 3'h1 << c;
                repeat (4) @(posedge clk);
                chk("rise", (p != 0) ? 32'h0 : 32'h1, {24'h0, pcnt - base});
                pins <= 3'h0;
                repeat (4) @(posedge clk);
                chk("fall", 32'h1, {24'h0, pcnt - base});
            end
        axi_rd(OFF_IRQ_STAT);
        chk("edge status", 32'h70, d);
        chk("edge irq", 32'h1, {31'h0, irq});
        axi_wr(OFF_CTL_ONE, 16'h8000);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axi_rd(OFF_CTL_ONE);
        chk("ctl_one after reset", 32'h0, d);
        chk("nesting after reset", 32'h0, {31'h0, nest});
        chk("prio after reset", 32'h0, {28'h0, prio});
        axi_rd(OFF_CTL_TWO);
        chk("ctl_two after reset", 32'h0, d);
        axi_rd(12'h100);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
        axi_wr(12'h100, 16'hffff);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        tally_and_finish;
    end
endmodule : tb
